// ### src/flh_pkg.sv
// shared constants and types for the huge page entry decoder
package flh_pkg;

    // -------------------------------------------------------------
    // entry geometry
    // -------------------------------------------------------------
    localparam int ENTRY_W = 64;          // width of one paging entry
    localparam int HOST_ADDR_WIDTH = 48;  // host address width, fixed
    localparam int NO_EXECUTE_BIT = 63;   // no_execute_bit position
    localparam int RSVD_HI_MSB = 51;      // top of upper reserved run
    localparam int FRAME_LSB = 30;        // 1-gbyte frame base lsb
    localparam int RSVD_LO_MSB = 29;      // lower reserved run msb
    localparam int RSVD_LO_LSB = 13;      // lower reserved run lsb
    localparam int MEM_ATTR_INDEX_BIT = 12;
    localparam int DIR_LSB = 12;          // next-level table base lsb
    localparam int EXT_USED_BIT = 10;     // extended_used_flag
    localparam int GLOBAL_BIT = 8;
    localparam int SIZE_SELECT_BIT = 7;
    localparam int DIRTY_BIT = 6;
    localparam int ACCESSED_BIT = 5;
    localparam int CACHE_OFF_BIT = 4;
    localparam int WRITE_THRU_BIT = 3;
    localparam int USER_SUP_BIT = 2;
    localparam int READ_WRITE_BIT = 1;
    localparam int PRESENT_BIT = 0;

    // -------------------------------------------------------------
    // register map (byte offsets) and values
    // -------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;      // context enables
    localparam logic [7:0] OFF_CAP = 8'h04;       // capability, read only
    localparam logic [7:0] OFF_ENTRY_LO = 8'h08;  // entry bits 31:0
    localparam logic [7:0] OFF_ENTRY_HI = 8'h0c;  // entry bits 63:32
    localparam logic [7:0] OFF_REQ = 8'h10;       // request attributes
    localparam logic [7:0] OFF_CMD = 8'h14;       // command, write only
    localparam logic [7:0] OFF_STATUS = 8'h18;    // decode result
    localparam logic [7:0] OFF_ADDR_LO = 8'h1c;   // output address low
    localparam logic [7:0] OFF_ADDR_HI = 8'h20;   // output address high
    localparam int CMD_GO_BIT = 0;                // starts one decode
    localparam logic HUGE_PAGE_CAPABILITY = 1'b1; // huge_page_capability
    localparam logic EXTENDED_USED_SUPPORTED = 1'b1;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } flh_bus_s;

    // governing extended context, bit 0 is no-exec enforcement
    typedef struct packed {
        logic coherent;
        logic supervisor_write_protect;
        logic global_pages_enable;
        logic extended_used_feature_on;
        logic nested_xlate_enable;
        logic no_exec_enforce_enable;
    } flh_ctx_s;

    // request attributes, bit 0 is user privilege
    typedef struct packed {
        logic exec;
        logic write;
        logic user;
    } flh_req_s;

    typedef struct packed {
        logic huge;
        logic next_level;
        logic not_present;
        logic rsvd_fault;
        logic global_page;
        logic nested;
        logic memtype_valid;
        logic [2:0] memtype;
        logic [63:0] addr;
    } flh_dec_s;

    typedef struct packed {
        logic user_deny;
        logic write_deny;
        logic exec_deny;
        logic granted;
    } flh_perm_s;

    // status register layout, bit 0 is busy
    typedef struct packed {
        logic [15:0] zero;
        logic [2:0] memtype;
        logic memtype_valid;
        logic nested;
        logic global_page;
        logic granted;
        logic exec_deny;
        logic write_deny;
        logic user_deny;
        logic rsvd_fault;
        logic not_present;
        logic next_level;
        logic huge;
        logic done;
        logic busy;
    } flh_status_s;

    typedef enum logic [1:0] {
        FLH_IDLE = 2'b00,
        FLH_CHECK = 2'b01,
        FLH_UPDATE = 2'b11
    } flh_state_e;

endpackage

// ### src/flh_fields.sv
// field extraction of one first-level paging entry
`timescale 1ns/1ps
module flh_fields (
    input wire logic [63:0] entry,
    input flh_pkg::flh_ctx_s ctx,
    output flh_pkg::flh_dec_s dec
);
    import flh_pkg::*;

    // -------------------------------------------------------------
    // decode, pure combinational
    // -------------------------------------------------------------
    always_comb begin
        dec = '0;
        dec.not_present = ~entry[PRESENT_BIT];
        // size bit picks page or table
        dec.huge = entry[PRESENT_BIT] & entry[SIZE_SELECT_BIT];
        dec.next_level = entry[PRESENT_BIT] & ~entry[SIZE_SELECT_BIT];
        dec.rsvd_fault = dec.huge & ((|entry[RSVD_HI_MSB:HOST_ADDR_WIDTH])
                         | (|entry[RSVD_LO_MSB:RSVD_LO_LSB]));
        if (dec.huge) begin
            dec.addr[HOST_ADDR_WIDTH-1:FRAME_LSB] = entry[HOST_ADDR_WIDTH-1:FRAME_LSB];
        end else if (dec.next_level) begin
            // table base for the next walk step
            dec.addr[HOST_ADDR_WIDTH-1:DIR_LSB] = entry[HOST_ADDR_WIDTH-1:DIR_LSB];
        end
        dec.nested = entry[PRESENT_BIT] & ctx.nested_xlate_enable;
        dec.global_page = dec.huge & ctx.global_pages_enable & entry[GLOBAL_BIT];
        if (dec.huge && ctx.coherent) begin
            dec.memtype_valid = 1'b1;
            dec.memtype = {entry[MEM_ATTR_INDEX_BIT], entry[CACHE_OFF_BIT],
                           entry[WRITE_THRU_BIT]};
        end
    end

endmodule

// ### src/flh_perm.sv
// permission check against one 1-gbyte page entry
`timescale 1ns/1ps
module flh_perm (
    input wire logic [63:0] entry,
    input flh_pkg::flh_ctx_s ctx,
    input flh_pkg::flh_req_s req,
    input flh_pkg::flh_dec_s dec,
    output flh_pkg::flh_perm_s perm
);
    import flh_pkg::*;

    // -------------------------------------------------------------
    // access rights, pure combinational
    // -------------------------------------------------------------
    always_comb begin
        perm = '0;
        perm.user_deny = req.user & ~entry[USER_SUP_BIT];
        perm.write_deny = req.write & ~entry[READ_WRITE_BIT]
                          & (req.user | ctx.supervisor_write_protect);
        perm.exec_deny = req.exec & ctx.no_exec_enforce_enable & entry[NO_EXECUTE_BIT];
        // only a clean huge mapping can grant
        perm.granted = dec.huge & ~dec.rsvd_fault & ~perm.user_deny
                       & ~perm.write_deny & ~perm.exec_deny;
    end

endmodule

// ### src/flh_top.sv
// register-driven decoder for first-level entries mapping 1-gbyte pages
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module flh_top (
    input wire logic clk,
    input wire logic rstn,
    input flh_pkg::flh_bus_s bus,
    output logic [31:0] rdata,
    output logic xlate_done,
    output logic xlate_granted,
    output logic xlate_nested,
    output logic [63:0] xlate_addr
);
    import flh_pkg::*;

    // -------------------------------------------------------------
    // register map, byte offsets on the plain port
    // -------------------------------------------------------------
    // 0x00 context enables, read and write:
    //   b0 no-exec enforcement, b1 nested translation,
    //   b2 extended-used feature, b3 global pages,
    //   b4 supervisor write protection, b5 coherent device
    // 0x04 capability, read only:
    //   b0 huge page support, b1 extended-used support
    // 0x08 entry bits 31:0, 0x0c entry bits 63:32, read and write;
    //   hardware ors the accessed, extended-used and dirty flags in
    // 0x10 request attributes: b0 user, b1 write, b2 execute
    // 0x14 command, write only: b0 starts one decode
    // 0x18 status, read only: b0 busy, b1 done, the rest as in the
    //   status struct, reading zero until a decode has finished
    // 0x1c output address low word, 0x20 high word, read only
    // unmapped offsets read zero and ignore writes
    //
    // sequencer timing, counted from the edge that takes a go write:
    //   edge 0 leaves idle for the check step
    //   edge 1 latches decode and permissions, address output moves
    //   edge 2 sets entry flags, raises done for one cycle
    //   a go seen outside idle is dropped without any indication
    //
    // hazards a user must know:
    //   context, request and entry are read as they stand right after
    //   the go; a context or request write in the check step still steers the flag update
    //   a software write to the entry during the flag update step
    //   lands first, the hardware flags are ored on top of it
    //   result levels drop on the next go, not on a new entry write

    // -------------------------------------------------------------
    // state of the whole block
    // -------------------------------------------------------------
    typedef struct packed {
        flh_state_e st;        // sequencer state
        flh_ctx_s ctx;         // context enables
        logic [63:0] entry;    // entry under test
        flh_req_s req;         // request attributes
        flh_dec_s dec;         // latched decode
        flh_perm_s perm;       // latched permissions
        logic done;            // result valid
        logic done_pulse;      // one cycle at finish
        logic granted;         // granted level, held until next go
        logic nested;          // nested level, held until next go
        logic [31:0] rdata;    // read data, one cycle late
    } flh_top_s;

    flh_top_s q;         // registered state
    flh_top_s d;         // next state
    flh_dec_s dec_w;     // live decode of held entry
    flh_perm_s perm_w;   // live permission result
    flh_status_s stat_w; // status word view
    logic go_w;          // start command seen
    logic busy_w;        // decode in progress
    logic used_w;        // entry used for translation

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // write strobe aimed at one offset
    function automatic logic wr_hit(input flh_bus_s b, input logic [7:0] off);
        wr_hit = b.wr && (b.addr == off);
    endfunction

    // read strobe aimed at one offset
    function automatic logic rd_hit(input flh_bus_s b, input logic [7:0] off);
        rd_hit = b.rd && (b.addr == off);
    endfunction

    // -------------------------------------------------------------
    // decode datapath
    // -------------------------------------------------------------
    // field extraction from held entry
    flh_fields u_fields (
        .entry(q.entry),
        .ctx(q.ctx),
        .dec(dec_w)
    );

    // access rights from held entry
    flh_perm u_perm (
        .entry(q.entry),
        .ctx(q.ctx),
        .req(q.req),
        .dec(dec_w),
        .perm(perm_w)
    );

    // -------------------------------------------------------------
    // status view
    // -------------------------------------------------------------
    // sequencer is busy outside idle
    assign busy_w = (q.st != FLH_IDLE);

    // start command bit on command write
    assign go_w = wr_hit(bus, OFF_CMD) && bus.wdata[CMD_GO_BIT];

    // used means mapped without reserved fault
    assign used_w = q.dec.huge & ~q.dec.rsvd_fault;

    // assemble status word
    always_comb begin
        stat_w = '0;
        stat_w.busy = busy_w;
        stat_w.done = q.done;
        // results only meaningful once done
        if (q.done) begin
            stat_w.huge = q.dec.huge;
            stat_w.next_level = q.dec.next_level;
            stat_w.not_present = q.dec.not_present;
            stat_w.rsvd_fault = q.dec.rsvd_fault;
            stat_w.user_deny = q.perm.user_deny;
            stat_w.write_deny = q.perm.write_deny;
            stat_w.exec_deny = q.perm.exec_deny;
            stat_w.granted = q.perm.granted;
            stat_w.global_page = q.dec.global_page;
            stat_w.nested = q.dec.nested;
            stat_w.memtype_valid = q.dec.memtype_valid;
            stat_w.memtype = q.dec.memtype;
        end
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        d = q;
        d.done_pulse = 1'b0;
        d.rdata = RDATA_IDLE;

        // read mux, answered in the next cycle
        if (rd_hit(bus, OFF_CTRL)) begin
            // context enables
            d.rdata[$bits(flh_ctx_s)-1:0] = q.ctx;
        end else if (rd_hit(bus, OFF_CAP)) begin
            d.rdata[0] = HUGE_PAGE_CAPABILITY;
            d.rdata[1] = EXTENDED_USED_SUPPORTED;
        end else if (rd_hit(bus, OFF_ENTRY_LO)) begin
            // entry low word, shows updated flags
            d.rdata = q.entry[31:0];
        end else if (rd_hit(bus, OFF_ENTRY_HI)) begin
            // entry high word
            d.rdata = q.entry[63:32];
        end else if (rd_hit(bus, OFF_REQ)) begin
            // request attributes
            d.rdata[$bits(flh_req_s)-1:0] = q.req;
        end else if (rd_hit(bus, OFF_STATUS)) begin
            // decode result and busy
            d.rdata = stat_w;
        end else if (rd_hit(bus, OFF_ADDR_LO)) begin
            // output address low word
            d.rdata = q.dec.addr[31:0];
        end else if (rd_hit(bus, OFF_ADDR_HI)) begin
            // output address high word
            d.rdata = q.dec.addr[63:32];
        end else begin
            // unmapped or no read reads as zero
            d.rdata = RDATA_IDLE;
        end

        // software writes
        if (wr_hit(bus, OFF_CTRL)) begin
            // context enables
            d.ctx = flh_ctx_s'(bus.wdata[$bits(flh_ctx_s)-1:0]);
        end else if (wr_hit(bus, OFF_ENTRY_LO)) begin
            // entry low word
            d.entry[31:0] = bus.wdata;
        end else if (wr_hit(bus, OFF_ENTRY_HI)) begin
            // entry high word
            d.entry[63:32] = bus.wdata;
        end else if (wr_hit(bus, OFF_REQ)) begin
            // request attributes
            d.req = flh_req_s'(bus.wdata[$bits(flh_req_s)-1:0]);
        end

        // sequencer, after writes so hardware flag sets win
        case (q.st)
            FLH_IDLE: begin
                // start only from idle, go while busy is dropped
                if (go_w) begin
                    d.done = 1'b0;
                    // result levels drop with the go
                    d.granted = 1'b0;
                    d.nested = 1'b0;
                    d.st = FLH_CHECK;
                end
            end
            FLH_CHECK: begin
                d.dec = dec_w;
                d.perm = perm_w;
                d.st = FLH_UPDATE;
            end
            FLH_UPDATE: begin
                if (used_w) begin
                    d.entry[ACCESSED_BIT] = 1'b1;
                end
                if (used_w && EXTENDED_USED_SUPPORTED && q.ctx.extended_used_feature_on) begin
                    d.entry[EXT_USED_BIT] = 1'b1;
                end
                if (q.perm.granted && q.req.write) begin
                    d.entry[DIRTY_BIT] = 1'b1;
                end
                d.done = 1'b1;
                d.done_pulse = 1'b1;
                // result levels rise beside the done pulse
                d.granted = q.perm.granted;
                d.nested = q.dec.nested;
                d.st = FLH_IDLE;
            end
            default: begin
                // unused code, recover to idle
                d.st = FLH_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------
    // outputs, straight from flops
    // -------------------------------------------------------------
    assign rdata = q.rdata;
    assign xlate_done = q.done_pulse;
    assign xlate_granted = q.granted;
    assign xlate_nested = q.nested;
    assign xlate_addr = q.dec.addr;

endmodule

// ### verification/flh_top_props.sv
// concurrent checks on the ports of the huge page entry decoder
`timescale 1ns/1ps
module flh_top_props (
    input wire logic clk,
    input wire logic rstn,
    input flh_pkg::flh_bus_s bus,
    input wire logic [31:0] rdata,
    input wire logic xlate_done,
    input wire logic xlate_granted,
    input wire logic xlate_nested,
    input wire logic [63:0] xlate_addr
);
    import flh_pkg::*;
    // ---------------------------------------------------------
    // helper: which go writes start a decode
    // ---------------------------------------------------------
    logic go; // go write seen on the bus
    logic acc_go; // go taken while idle
    logic [1:0] busy_q; // cycles left before idle
    assign go = bus.wr && bus.addr == OFF_CMD && bus.wdata[CMD_GO_BIT];
    assign acc_go = go && busy_q == 2'h0;
    // count down the busy window after a taken go
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 2'h0;
        end else if (acc_go) begin
            busy_q <= 2'h2;
        end else if (busy_q != 2'h0) begin
            busy_q <= busy_q - 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ---------------------------------------------------------
    // assertions
    // ---------------------------------------------------------
    AST_GO_DONE: assert property (acc_go |-> ##3 xlate_done)
        else $error("decode did not finish three cycles after go");
    AST_DONE_CAUSE: assert property (xlate_done |-> $past(acc_go, 3))
        else $error("done pulse without a taken go");
    AST_DONE_PULSE: assert property (xlate_done |=> !xlate_done)
        else $error("done pulse longer than one cycle");
    AST_LEVEL_CHANGE: assert property (
        ($changed(xlate_granted) || $changed(xlate_nested)) |-> xlate_done || $past(acc_go))
        else $error("result level moved outside done or go");
    AST_GRANT_CLEAR: assert property (acc_go |=> !xlate_granted && !xlate_nested)
        else $error("result levels not cleared by go");
    AST_ADDR_TIMING: assert property (!$stable(xlate_addr) |-> $past(acc_go, 2))
        else $error("address moved outside the check step");
    AST_ADDR_ALIGN: assert property (
        xlate_addr[63:48] == 16'h0000 && xlate_addr[11:0] == 12'h000)
        else $error("address outside host width or unaligned");
    AST_CAP_VALUE: assert property (
        bus.rd && bus.addr == OFF_CAP |=> rdata == 32'h0000_0003)
        else $error("capability read wrong");
    AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == RDATA_IDLE)
        else $error("read data not idle");
    // ---------------------------------------------------------
    // covers
    // ---------------------------------------------------------
    cover property (xlate_done && xlate_granted);
    cover property (xlate_done && !xlate_granted);
    cover property (xlate_done && xlate_nested);
    cover property (go && !acc_go);
endmodule

bind flh_top flh_top_props u_props (
    .clk(clk),
    .rstn(rstn),
    .bus(bus),
    .rdata(rdata),
    .xlate_done(xlate_done),
    .xlate_granted(xlate_granted),
    .xlate_nested(xlate_nested),
    .xlate_addr(xlate_addr)
);

// ### verification/flh_dev_model.sv
// requesting agent that programs and reads the decoder over its register port
`timescale 1ns/1ps
module flh_dev_model (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output flh_pkg::flh_bus_s bus
);
    import flh_pkg::*;
    // bus idle from time zero
    initial begin
        bus = '0;
    end
    // one-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

// ### verification/test_first_level_huge_page_entry_decode.sv
// self-checking bench for the huge page entry decoder
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_first_level_huge_page_entry_decode;
    import flh_pkg::*;
    logic clk; // 200 MHz
    logic rstn; // active low reset
    flh_bus_s bus; // register port
    logic [31:0] rdata;
    logic xlate_done, xlate_granted, xlate_nested;
    logic [63:0] xlate_addr;
    int error_cnt = 0; // mismatches
    int checked = 0; // comparisons
    int cyc = 0; // cycle counter for the hang guard
    // ---------------------------------------------------------
    // design and agent
    // ---------------------------------------------------------
    flh_top DUT (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .xlate_done(xlate_done),
        .xlate_granted(xlate_granted), .xlate_nested(xlate_nested), .xlate_addr(xlate_addr));
    flh_dev_model DEV (.clk(clk), .rdata(rdata), .bus(bus));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read one register and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        DEV.rd(a, d);
        `CHECK_EQ(d, exp)
    endtask
    // wait for the done pulse, bounded
    task automatic wait_done();
        #1;
        repeat (20) begin
            if (xlate_done === 1'b1) break;
            @(posedge clk);
            #1;
        end
        `CHECK_EQ(xlate_done, 1'b1)
    endtask
    // expected status, entry after flag update, output address
    function automatic void model(input logic [5:0] c, input logic [63:0] e,
        input logic [2:0] r, output logic [15:0] s, output logic [63:0] ne,
        output logic [63:0] a);
        logic hp, nl, rs, ud, wd, xn, g, mv;
        hp = e[0] & e[7];
        nl = e[0] & !e[7];
        rs = (|e[51:48]) | (|e[29:13]);
        ud = r[0] & !e[2];
        wd = r[1] & !e[1] & (r[0] | c[4]);
        xn = r[2] & c[0] & e[63];
        g = hp & !rs & !ud & !wd & !xn;
        mv = hp & c[5];
        s = {mv ? {e[12], e[4], e[3]} : 3'b000, mv, c[1] & e[0], hp & c[3] & e[8], g, xn,
            wd, ud, rs, !e[0], nl, hp, 1'b1, 1'b0};
        ne = e;
        if (hp && !rs) begin
            ne[5] = 1'b1;
            ne[10] = e[10] | c[2];
            ne[6] = e[6] | (g & r[1]);
        end
        a = hp ? {16'h0, e[47:30], 30'h0} : (nl ? {16'h0, e[47:12], 12'h0} : 64'h0);
    endfunction
    // ---------------------------------------------------------
    // decode cases: context, entry, request
    // ---------------------------------------------------------
    logic [5:0] tc [12] = '{6'h00, 6'h3f, 6'h00, 6'h00, 6'h10, 6'h00, 6'h2e, 6'h00, 6'h00,
        6'h21, 6'h02, 6'h00};
    logic [63:0] te [12] = '{64'h7ff0_7fc0_4000_0b87, 64'h8000_0001_c000_1199,
        64'h0000_0000_4000_0085, 64'h0000_0000_4000_0085, 64'h0000_0000_4000_0085,
        64'h0000_0000_8000_0083, 64'h0001_0000_4000_1087, 64'h0000_0000_4000_2087,
        64'h8000_0000_4000_109f, 64'h8000_0000_4000_008f, 64'h0000_1234_5678_9007,
        64'h0000_0000_4000_0086};
    logic [2:0] tr [12] = '{3'h3, 3'h6, 3'h3, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0, 3'h4, 3'h4,
        3'h0, 3'h3};
    initial begin
        logic [15:0] s, m;
        logic [63:0] ne, a;
        logic [31:0] d;
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // registers: reset, read only, unmapped
        rchk(OFF_CTRL, 32'h0);
        rchk(OFF_CAP, 32'h3);
        DEV.wr(OFF_CAP, 32'h0);
        rchk(OFF_CAP, 32'h3);
        DEV.wr(8'h40, 32'hffff_ffff);
        rchk(8'h40, 32'h0);
        DEV.wr(OFF_CTRL, 32'hffff_ffff);
        rchk(OFF_CTRL, 32'h3f);
        for (int i = 0; i < 12; i++) begin
            model(tc[i], te[i], tr[i], s, ne, a);
            DEV.wr(OFF_CTRL, {26'h0, tc[i]});
            DEV.wr(OFF_ENTRY_LO, te[i][31:0]);
            DEV.wr(OFF_ENTRY_HI, te[i][63:32]);
            DEV.wr(OFF_REQ, {29'h0, tr[i]});
            DEV.wr(OFF_CMD, 32'h1);
            // a second go while busy must be dropped
            if (i == 0) DEV.wr(OFF_CMD, 32'h1);
            // busy shows and results stay hidden in the flag update step
            if (i == 1) rchk(OFF_STATUS, 32'h1);
            wait_done();
            `CHECK_EQ(xlate_granted, s[9])
            `CHECK_EQ(xlate_nested, s[11])
            `CHECK_EQ(xlate_addr, a)
            m = (te[i][0] && te[i][7]) ? 16'hffff : 16'h021e;
            DEV.rd(OFF_STATUS, d);
            `CHECK_EQ(d[15:0] & m, s & m)
            rchk(OFF_ENTRY_LO, ne[31:0]);
            rchk(OFF_ENTRY_HI, ne[63:32]);
            rchk(OFF_ADDR_LO, a[31:0]);
            rchk(OFF_ADDR_HI, a[63:32]);
            rchk(OFF_REQ, {29'h0, tr[i]});
        end
        stop_test();
    end
endmodule
